// ==== inc/pmac_pkg.sv ====
// Purpose: Constants and types for the power meter acquisition controller
// Assumes: APB register access, 16-bit signed converter samples
// Notes:   Offsets are byte addresses, one 32-bit word per register
package pmac_pkg;
   localparam int AW = 8;
   localparam int SW = 16;
   localparam int AC = 48;
   localparam int MAX_PERIODS = 8;
   localparam logic [AW-1:0] OFF_CTRL   = 8'h00;
   localparam logic [AW-1:0] OFF_CFG    = 8'h04;
   localparam logic [AW-1:0] OFF_STAT   = 8'h08;
   localparam logic [AW-1:0] OFF_SAMP   = 8'h0C;
   localparam logic [AW-1:0] OFF_PV     = 8'h10;
   localparam logic [AW-1:0] OFF_PC     = 8'h1C;
   localparam logic [AW-1:0] OFF_VSH    = 8'h28;
   localparam logic [AW-1:0] OFF_CSH    = 8'h34;
   localparam logic [AW-1:0] OFF_RV     = 8'h40;
   localparam logic [AW-1:0] OFF_RI     = 8'h4C;
   localparam logic [AW-1:0] OFF_RP     = 8'h58;
   localparam logic [AW-1:0] OFF_RE     = 8'h64;
   localparam logic [AW-1:0] REG_STRIDE = 8'h04;
   localparam int CTRL_RUN    = 0;
   localparam int CTRL_STOP   = 1;
   localparam int CTRL_XFER   = 2;
   localparam int CFG_NET_LSB = 0;
   localparam int CFG_MODE    = 3;
   localparam int CFG_PER_LSB = 4;
   localparam int CFG_THR_LSB = 8;
   localparam int CFG_W       = 15;
   localparam int SHUNT_SHIFT = 12;
   localparam logic [11:0] SAMP_CONTINUOUS_MODE = 12'h0C8;
   localparam logic [11:0] SAMP_EXTERNAL_TRIGGER_INPUT = 12'h064;
   localparam logic [3:0]  ONE_PER   = 4'h1;
   localparam logic [3:0]  MAX_PER   = 4'h8;
   // One twentieth of full scale
   localparam logic [15:0] LEVEL_MIN = 16'h0666;
   localparam logic [15:0] I1_FULL   = 16'h7FFF;
   localparam logic [7:0]  PCT_FULL  = 8'h64;
   localparam logic [6:0]  THR_NONE  = 7'h00;
   // Channel use per network, index is the network code
   localparam logic [2:0] NET_VMASK [8] =
      '{3'h1, 3'h3, 3'h7, 3'h1, 3'h3, 3'h1, 3'h3, 3'h7};
   localparam logic [2:0] NET_IMASK [8] =
      '{3'h1, 3'h3, 3'h7, 3'h1, 3'h3, 3'h1, 3'h7, 3'h7};
   typedef enum logic [2:0] {
      single_phase_one_pair,
      single_phase_two_pairs,
      single_phase_three_pairs,
      three_wire_one_v_one_i,
      three_wire_two_v_two_i,
      four_wire_one_v_one_i,
      four_wire_two_v_three_i,
      four_wire_three_v_three_i
   } pmac_net_t;
   typedef struct packed {
      logic [2:0][SW-1:0] v;
      logic [2:0][SW-1:0] i;
   } pmac_sample_t;
   typedef struct packed {
      logic        valid;
      logic [7:0]  index;
      logic [31:0] data;
   } pmac_xfer_t;
endpackage

// ==== verilog/pmac_top.sv ====
// Purpose: Acquisition and computation controller of a power meter board
// Assumes: Samples and mains period marker come from logic on pclk
// Notes:   Trigger pin is synchronised, registers on APB
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Take three voltage and three current samples, far faster than mains.
// - Each acquisition spans one to eight whole mains periods.
// - Compute squared sums, powers and energies per channel from each acquisition.
// - Measure only while voltage input 1 exceeds a twentieth of full scale.
// - Continuous mode repeats acquisitions and keeps the newest results readable.
// - An unread result is simply overwritten by the next one.
// - Continuous mode picks the period count giving 200 samples.
// - A configured count of one to eight periods replaces that choice.
// - Triggered runs start on the run command or a rise of the trigger level.
// - Triggered acquisitions use the count giving 100 samples, results buffered.
// - A run ends on full buffer, stop command or, for a run started by the trigger, trigger loss.
// - After a run, the transfer command copies the buffer to storage.
// - With a threshold, storing starts once current 1 exceeds it.
// - Configuration items arrive together as one configuration word.
// - Eight network types select which inputs are measured.
// - Primary voltage setting scales the voltage results.
// - Primary current setting scales the current results.
// - Single-phase networks use separate primary values per pair.
// - Shunt values correct the voltage and current results for input impedance.
// - Single-phase networks use separate shunt values per channel.
module pmac_top
#(
   parameter int BUF_DEPTH = 16
)
(
   // Clock and reset
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   // APB slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [pmac_pkg::AW-1:0] paddr,
   input  wire logic [31:0]            pwdata,
   output var  logic [31:0]            prdata,
   output var  logic                   pready,
   output var  logic                   pslverr,
   // Converter samples and mains period marker
   input  wire logic                   adc_valid,
   input  wire pmac_pkg::pmac_sample_t adc_sample,
   input  wire logic                   mains_tick,
   // Trigger pin
   input  wire logic                   external_trigger_input,
   // Storage memory transfer and status
   output var  pmac_pkg::pmac_xfer_t   xfer,
   output var  logic                   acq_busy
);

   localparam int PW = $clog2(BUF_DEPTH);
   localparam logic [PW:0] DEPTH_W = (PW+1)'(BUF_DEPTH);
   localparam logic [PW:0] PTR_ONE = (PW+1)'(1);

   typedef enum logic [1:0] {st_idle, st_acq, st_xfer} pmac_st_t;

   typedef struct packed {
      logic [2:0]                    external_trigger_input_s;
      logic                          external_trigger_input_lvl;
      logic                          external_trigger_input_start;
      pmac_st_t                      st;
      logic [pmac_pkg::CFG_W-1:0]    cfg;
      logic [2:0][15:0]              pv;
      logic [2:0][15:0]              pc;
      logic [2:0][15:0]              vsh;
      logic [2:0][15:0]              csh;
      logic [11:0]                   scnt;
      logic [11:0]                   spp;
      logic [15:0]                   v1pk;
      logic [15:0]                   i1pk;
      logic                          level_ok;
      logic [3:0]                    per_cnt;
      logic [3:0]                    per_tgt;
      logic [15:0]                   nsamp;
      logic [15:0]                   last_nsamp;
      logic [2:0][pmac_pkg::AC-1:0]  vsq;
      logic [2:0][pmac_pkg::AC-1:0]  isq;
      logic [2:0][pmac_pkg::AC-1:0]  pacc;
      logic [2:0][31:0]              rv;
      logic [2:0][31:0]              ri;
      logic [2:0][31:0]              rp;
      logic [2:0][31:0]              re;
      logic                          armed;
      logic                          gate;
      logic [BUF_DEPTH-1:0][31:0]    mem;
      logic [PW:0]                   wptr;
      logic [PW:0]                   rptr;
      pmac_pkg::pmac_xfer_t          xfer;
      logic                          busy;
      logic [31:0]                   prdata;
      logic                          pready;
      logic                          pslverr;
   } pmac_state_t;

   pmac_state_t          q;
   pmac_state_t          n;
   logic                 req;
   logic                 wr;
   logic                 hit;
   logic [31:0]          rd;
   logic                 cmd_run;
   logic                 cmd_stop;
   logic                 cmd_xfer;
   logic                 external_trigger_input_rise;
   logic                 external_trigger_input_fall;
   logic                 external_trigger_input_mode;
   logic [6:0]           thr;
   logic                 thr_hit;
   logic [11:0]          tgt;
   logic [3:0]           auto_n;
   logic [3:0]           per_cfg;
   logic [3:0]           sel_n;
   pmac_pkg::pmac_net_t  net;
   logic [2:0]           vmask;
   logic [2:0]           imask;
   logic                 single;
   logic [15:0]          pvk;
   logic [15:0]          pck;
   logic [15:0]          vshk;
   logic [15:0]          cshk;
   logic [31:0]          sv;
   logic [31:0]          si;
   logic [31:0]          ptot;
   logic [pmac_pkg::AW-1:0] lane;

   function automatic logic [15:0] mag(input logic [15:0] x);
      mag = x[15] ? 16'(-x) : x;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      n = q;
      n.xfer.valid = 1'h0;
      req = psel && penable;
      wr = req && q.pready && pwrite;
      hit = 1'h0;
      rd = 32'h0000_0000;
      lane = '0;
      pvk = '0;
      pck = '0;
      vshk = '0;
      cshk = '0;
      sv = '0;
      si = '0;
      ptot = '0;
      external_trigger_input_mode = q.cfg[pmac_pkg::CFG_MODE];
      thr = q.cfg[pmac_pkg::CFG_THR_LSB +: 7];
      per_cfg = q.cfg[pmac_pkg::CFG_PER_LSB +: 4];
      net = pmac_pkg::pmac_net_t'(q.cfg[pmac_pkg::CFG_NET_LSB +: 3]);
      vmask = pmac_pkg::NET_VMASK[q.cfg[pmac_pkg::CFG_NET_LSB +: 3]];
      imask = pmac_pkg::NET_IMASK[q.cfg[pmac_pkg::CFG_NET_LSB +: 3]];
      single = (net <= pmac_pkg::single_phase_three_pairs);

      // Register decode and read mux
      if (paddr == pmac_pkg::OFF_CTRL)
         hit = 1'h1;
      if (paddr == pmac_pkg::OFF_CFG)
      begin
         hit = 1'h1;
         rd = 32'(q.cfg);
      end
      if (paddr == pmac_pkg::OFF_STAT)
      begin
         hit = 1'h1;
         rd = 32'({q.wptr, q.per_tgt, q.external_trigger_input_lvl, q.st == st_xfer, q.gate,
                   q.level_ok, q.armed});
      end
      if (paddr == pmac_pkg::OFF_SAMP)
      begin
         hit = 1'h1;
         rd = 32'(q.last_nsamp);
      end
      for (int k = 0; k < 3; k++)
      begin
         lane = pmac_pkg::REG_STRIDE * 8'(k);
         if (paddr == pmac_pkg::OFF_PV + lane)
         begin
            hit = 1'h1;
            rd = 32'(q.pv[k]);
            if (wr)
               n.pv[k] = pwdata[15:0];
         end
         if (paddr == pmac_pkg::OFF_PC + lane)
         begin
            hit = 1'h1;
            rd = 32'(q.pc[k]);
            if (wr)
               n.pc[k] = pwdata[15:0];
         end
         if (paddr == pmac_pkg::OFF_VSH + lane)
         begin
            hit = 1'h1;
            rd = 32'(q.vsh[k]);
            if (wr)
               n.vsh[k] = pwdata[15:0];
         end
         if (paddr == pmac_pkg::OFF_CSH + lane)
         begin
            hit = 1'h1;
            rd = 32'(q.csh[k]);
            if (wr)
               n.csh[k] = pwdata[15:0];
         end
         // Results are overwritten whether read or not
         if (paddr == pmac_pkg::OFF_RV + lane)
         begin
            hit = 1'h1;
            rd = q.rv[k];
         end
         if (paddr == pmac_pkg::OFF_RI + lane)
         begin
            hit = 1'h1;
            rd = q.ri[k];
         end
         if (paddr == pmac_pkg::OFF_RP + lane)
         begin
            hit = 1'h1;
            rd = q.rp[k];
         end
         if (paddr == pmac_pkg::OFF_RE + lane)
         begin
            hit = 1'h1;
            rd = q.re[k];
         end
      end
      if (wr && paddr == pmac_pkg::OFF_CFG)
         n.cfg = pwdata[pmac_pkg::CFG_W-1:0];
      cmd_run = wr && paddr == pmac_pkg::OFF_CTRL && pwdata[pmac_pkg::CTRL_RUN];
      cmd_stop = wr && paddr == pmac_pkg::OFF_CTRL && pwdata[pmac_pkg::CTRL_STOP];
      cmd_xfer = wr && paddr == pmac_pkg::OFF_CTRL && pwdata[pmac_pkg::CTRL_XFER];
      // One wait state on every access
      n.pready = req && !q.pready;
      n.pslverr = req && !q.pready && !hit;
      if (req && !q.pready)
         n.prdata = rd;

      // Trigger pin synchroniser, level taken when stages two and three agree
      n.external_trigger_input_s = {q.external_trigger_input_s[1:0], external_trigger_input};
      external_trigger_input_rise = (q.external_trigger_input_s[1] == q.external_trigger_input_s[2]) && q.external_trigger_input_s[2] && !q.external_trigger_input_lvl;
      external_trigger_input_fall = (q.external_trigger_input_s[1] == q.external_trigger_input_s[2]) && !q.external_trigger_input_s[2] && q.external_trigger_input_lvl;
      if (q.external_trigger_input_s[1] == q.external_trigger_input_s[2])
         n.external_trigger_input_lvl = q.external_trigger_input_s[2];

      // Period length and peak tracking
      thr_hit = (24'(q.i1pk) * 24'(pmac_pkg::PCT_FULL)) >=
                (24'(pmac_pkg::I1_FULL) * 24'(thr));
      if (adc_valid)
      begin
         n.scnt = q.scnt + 12'h001;
         if (mag(adc_sample.v[0]) > q.v1pk)
            n.v1pk = mag(adc_sample.v[0]);
         if (mag(adc_sample.i[0]) > q.i1pk)
            n.i1pk = mag(adc_sample.i[0]);
      end
      if (mains_tick)
      begin
         n.spp = q.scnt;
         n.scnt = '0;
         n.level_ok = (q.v1pk >= pmac_pkg::LEVEL_MIN);
         n.v1pk = '0;
         n.i1pk = '0;
         if (q.armed && thr_hit)
            n.gate = 1'h1;
      end

      // Period count choice
      tgt = external_trigger_input_mode ? pmac_pkg::SAMP_EXTERNAL_TRIGGER_INPUT : pmac_pkg::SAMP_CONTINUOUS_MODE;
      auto_n = pmac_pkg::MAX_PER;
      for (int k = pmac_pkg::MAX_PERIODS; k > 0; k--)
      begin
         if (16'(q.spp) * 16'(k) >= 16'(tgt))
            auto_n = 4'(k);
      end
      if (!external_trigger_input_mode && per_cfg >= pmac_pkg::ONE_PER && per_cfg <= pmac_pkg::MAX_PER)
         sel_n = per_cfg;
      else
         sel_n = auto_n;

      // Run control in triggered mode
      if (external_trigger_input_mode && !q.armed && q.st != st_xfer && (cmd_run || external_trigger_input_rise) && !cmd_stop)
      begin
         n.armed = 1'h1;
         n.wptr = '0;
         n.external_trigger_input_start = !cmd_run;
         n.gate = (thr == pmac_pkg::THR_NONE);
      end
      if (q.armed && (cmd_stop || (q.external_trigger_input_start && external_trigger_input_fall) || !external_trigger_input_mode))
         n.armed = 1'h0;

      case (q.st)
         st_idle:
         begin
            if (mains_tick && q.level_ok && (!external_trigger_input_mode || q.armed))
            begin
               n.st = st_acq;
               n.per_cnt = '0;
               n.per_tgt = sel_n;
               n.nsamp = '0;
               n.vsq = '0;
               n.isq = '0;
               n.pacc = '0;
            end
            else if (cmd_xfer && !q.armed && q.wptr != '0)
            begin
               n.st = st_xfer;
               n.rptr = '0;
            end
         end
         st_acq:
         begin
            if (adc_valid)
            begin
               n.nsamp = q.nsamp + 16'h0001;
               for (int k = 0; k < 3; k++)
               begin
                  if (vmask[k])
                     n.vsq[k] = q.vsq[k] + pmac_pkg::AC'($signed(adc_sample.v[k]) *
                                $signed(adc_sample.v[k]));
                  if (imask[k])
                     n.isq[k] = q.isq[k] + pmac_pkg::AC'($signed(adc_sample.i[k]) *
                                $signed(adc_sample.i[k]));
                  if (vmask[k] && imask[k])
                     n.pacc[k] = q.pacc[k] + pmac_pkg::AC'($signed(adc_sample.v[k]) *
                                 $signed(adc_sample.i[k]));
               end
            end
            if (!q.level_ok || (external_trigger_input_mode && !q.armed))
               n.st = st_idle;
            else if (mains_tick)
            begin
               n.per_cnt = q.per_cnt + pmac_pkg::ONE_PER;
               if (n.per_cnt == q.per_tgt)
               begin
                  n.last_nsamp = n.nsamp;
                  for (int k = 0; k < 3; k++)
                  begin
                     pvk = single ? q.pv[k] : q.pv[0];
                     pck = single ? q.pc[k] : q.pc[0];
                     vshk = single ? q.vsh[k] : q.vsh[0];
                     cshk = single ? q.csh[k] : q.csh[0];
                     sv = 32'(n.vsq[k][pmac_pkg::AC-1 -: 16]) * 32'(pvk);
                     si = 32'(n.isq[k][pmac_pkg::AC-1 -: 16]) * 32'(pck);
                     sv = sv + ((32'(sv[31:16]) * 32'(vshk)) >> pmac_pkg::SHUNT_SHIFT);
                     si = si + ((32'(si[31:16]) * 32'(cshk)) >> pmac_pkg::SHUNT_SHIFT);
                     n.rv[k] = vmask[k] ? sv : '0;
                     n.ri[k] = imask[k] ? si : '0;
                     n.rp[k] = (vmask[k] && imask[k]) ? n.pacc[k][pmac_pkg::AC-1 -: 32] : '0;
                     n.re[k] = q.re[k] + n.rp[k];
                     ptot = ptot + n.rp[k];
                  end
                  if (external_trigger_input_mode && n.gate && q.wptr < DEPTH_W)
                  begin
                     n.mem[q.wptr[PW-1:0]] = ptot;
                     n.wptr = q.wptr + PTR_ONE;
                     if (n.wptr == DEPTH_W)
                        n.armed = 1'h0;
                  end
                  n.per_cnt = '0;
                  n.per_tgt = sel_n;
                  n.nsamp = '0;
                  n.vsq = '0;
                  n.isq = '0;
                  n.pacc = '0;
               end
            end
         end
         st_xfer:
         begin
            n.xfer.valid = 1'h1;
            n.xfer.index = 8'(q.rptr);
            n.xfer.data = q.mem[q.rptr[PW-1:0]];
            n.rptr = q.rptr + PTR_ONE;
            if (n.rptr == q.wptr)
               n.st = st_idle;
         end
         default:
         begin
            n.st = st_idle;
         end
      endcase
      n.busy = n.armed || n.st == st_acq;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         q <= '0;
      else
         q <= n;
   end

   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign xfer = q.xfer;
   assign acq_busy = q.busy;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_ctrl_wr(int b);
      psel && penable && q.pready && pwrite && paddr == pmac_pkg::OFF_CTRL && pwdata[b];
   endsequence
   sequence s_xfer_go;
      q.st == st_idle ##1 q.st == st_xfer;
   endsequence

   AST_NO_START_LOW_LEVEL: assert property (
      (q.st == st_idle && !q.level_ok) |=> q.st != st_acq)
      else $error("acquisition started without voltage 1 level");
   AST_PERIODS_IN_RANGE: assert property (
      q.st == st_acq |-> (q.per_tgt >= pmac_pkg::ONE_PER && q.per_tgt <= pmac_pkg::MAX_PER))
      else $error("period count out of range");
   AST_FULL_ENDS_RUN: assert property (
      q.wptr == DEPTH_W |-> !q.armed)
      else $error("run continues with full buffer");
   AST_STOP_ENDS_RUN: assert property (
      s_ctrl_wr(pmac_pkg::CTRL_STOP) |=> !q.armed)
      else $error("stop command ignored");
   AST_STORE_ONLY_ARMED: assert property (
      ($changed(q.wptr) && q.wptr != '0) |-> ($past(q.armed) && q.gate && external_trigger_input_mode))
      else $error("buffer written outside a gated run");
   AST_XFER_STREAMS: assert property (
      s_xfer_go |=> (q.xfer.valid && q.xfer.index == 8'h00 && !q.armed))
      else $error("transfer did not start at entry zero");
   AST_MASKED_RESULT: assert property (
      $changed(q.rv[2]) |-> ($past(vmask[2]) || q.rv[2] == '0))
      else $error("result produced for unused input");
   AST_EXTERNAL_TRIGGER_INPUT_SYNC: assert property (
      $changed(q.external_trigger_input_lvl) |-> $past(q.external_trigger_input_s[1] == q.external_trigger_input_s[2]))
      else $error("trigger level taken before stages agreed");
   AST_ONE_WAIT: assert property (
      (req && !q.pready) |=> (q.pready ##1 !q.pready))
      else $error("bus answer timing wrong");

endmodule
`default_nettype wire

// ==== test/pmac_host.sv ====
// Purpose: APB host that fetches results at its own pace
// Assumes: One transfer at a time
// Notes:   Released address and data lines show inverted values
`timescale 1ns/100ps
`default_nettype none
module pmac_host
(
   // Clock
   input  wire logic                    pclk,
   // APB master
   output var  logic                    psel,
   output var  logic                    penable,
   output var  logic                    pwrite,
   output var  logic [pmac_pkg::AW-1:0] paddr,
   output var  logic [31:0]             pwdata,
   input  wire logic [31:0]             prdata,
   input  wire logic                    pready,
   input  wire logic                    pslverr
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end
   // Setup, access, hold until ready
   task automatic xfr(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Purpose: Self-checking bench for the power meter acquisition controller
// Assumes: 50 sample sets per mains period, currents at 0x4000
// Notes:   Buffer depth cut to 4 to keep triggered runs short
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic                    pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic                    adc_valid, mains_tick, ext_trigger, acq_busy, e;
   logic [pmac_pkg::AW-1:0] paddr;
   logic [31:0]             pwdata, prdata, q, e1;
   logic [15:0]             sv;
   logic [6:0]              cnt;
   pmac_pkg::pmac_sample_t  adc_sample;
   pmac_pkg::pmac_xfer_t    xfer;
   int                      miscompares, num_checks;
   ////////////////////////////////////////////////////////////
   pmac_top #(.BUF_DEPTH(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .adc_valid(adc_valid), .adc_sample(adc_sample),
      .mains_tick(mains_tick), .external_trigger_input(ext_trigger), .xfer(xfer),
      .acq_busy(acq_busy));
   pmac_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // Mains period: 50 sample sets, then one tick cycle
   always @(posedge pclk)
   begin
      cnt <= (cnt == 7'h64) ? 7'h00 : cnt + 7'h01;
      mains_tick <= (cnt == 7'h64);
      adc_valid <= (cnt < 7'h64) && !cnt[0];
      adc_sample <= {sv, sv, sv, 16'h4000, 16'h4000, 16'h4000};
   end
   ////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      num_checks++;
      if (g !== x)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic rd(input logic [7:0] a);
      host.xfr(1'b0, a, 32'h0000_0000, q, e);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.xfr(1'b1, a, d, q, e);
   endtask
   task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] x);
      rd(a);
      chk(n, x, q);
   endtask
   task automatic per(input int n);
      repeat (n * 101) @(posedge pclk);
   endtask
   function automatic logic [7:0] at(input logic [7:0] b, input int k);
      return 8'(b + pmac_pkg::REG_STRIDE * k);
   endfunction
   ////////////////////////////////////////////////////////////
   task automatic t_nets;
      logic [31:0] x;
      for (int k = 0; k < 3; k++)
      begin
         wr(at(pmac_pkg::OFF_PV, k), (k == 1) ? 32'h0000_0020 : 32'h0000_0010);
         wr(at(pmac_pkg::OFF_PC, k), 32'h0000_0020);
      end
      for (int n = 0; n < 8; n++)
      begin
         wr(pmac_pkg::OFF_CFG, 32'h0000_0010 | 32'(n));
         per(3);
         x = (n < 3) ? 32'h0000_0060 : 32'h0000_0030;
         rchk("volt2", at(pmac_pkg::OFF_RV, 1), pmac_pkg::NET_VMASK[n][1] ? x : 32'h0);
         x = pmac_pkg::NET_VMASK[n][2] ? 32'h0000_0030 : 32'h0000_0000;
         rchk("volt3", at(pmac_pkg::OFF_RV, 2), x);
         x = pmac_pkg::NET_IMASK[n][2] ? 32'h0000_0060 : 32'h0000_0000;
         rchk("curr3", at(pmac_pkg::OFF_RI, 2), x);
      end
   endtask
   task automatic t_continuous_mode;
      wr(pmac_pkg::OFF_CFG, 32'h0000_0011);
      per(3);
      rd(pmac_pkg::OFF_STAT);
      chk("period_target", 32'h0000_0001, 32'(q[8:5]));
      rchk("volt1", pmac_pkg::OFF_RV, 32'h0000_0030);
      rchk("samples", pmac_pkg::OFF_SAMP, 32'h0000_0032);
      rchk("power1", pmac_pkg::OFF_RP, 32'h0003_2000);
      rd(pmac_pkg::OFF_RE);
      e1 = q;
      repeat (299) @(posedge pclk);
      rd(pmac_pkg::OFF_RE);
      chk("energy_step", 32'h0009_6000, q - e1);
      wr(pmac_pkg::OFF_PV, 32'h0000_8000);
      wr(pmac_pkg::OFF_VSH, 32'h0000_3000);
      per(3);
      rchk("volt1_shunt", pmac_pkg::OFF_RV, 32'h0001_8003);
      wr(pmac_pkg::OFF_CFG, 32'h0000_0001);
      per(3);
      rd(pmac_pkg::OFF_STAT);
      chk("auto_target", 32'h0000_0004, 32'(q[8:5]));
      sv <= 16'h0600;
      per(3);
      rd(pmac_pkg::OFF_STAT);
      chk("level_low", 32'h0000_0000, 32'(q[1]));
      sv <= 16'h4000;
   endtask
   task automatic t_external_trigger_input;
      int n;
      wr(pmac_pkg::OFF_CFG, 32'h0000_0008);
      per(3);
      ext_trigger <= 1'b1;
      repeat (10) @(posedge pclk);
      chk("busy_on_trigger", 32'h0000_0001, 32'(acq_busy));
      per(1);
      rd(pmac_pkg::OFF_STAT);
      chk("external_trigger_input_target", 32'h0000_0002, 32'(q[8:5]));
      for (n = 0; n < 3000 && acq_busy !== 1'b0; n++)
         @(posedge pclk);
      chk("busy_when_full", 32'h0000_0000, 32'(acq_busy));
      rd(pmac_pkg::OFF_STAT);
      chk("entries", 32'h0000_0004, 32'(q[11:9]));
      wr(pmac_pkg::OFF_CTRL, 32'h0000_0004);
      n = 0;
      repeat (12)
      begin
         @(negedge pclk);
         if (xfer.valid === 1'b1)
         begin
            chk("xfer_index", 32'(n), 32'(xfer.index));
            chk("xfer_data", 32'h0006_4000, xfer.data);
            n++;
         end
      end
      chk("xfer_count", 32'h0000_0004, 32'(n));
      @(posedge pclk);
      ext_trigger <= 1'b0;
      repeat (10) @(posedge pclk);
      wr(pmac_pkg::OFF_CTRL, 32'h0000_0001);
      repeat (5) @(posedge pclk);
      chk("busy_on_run", 32'h0000_0001, 32'(acq_busy));
      wr(pmac_pkg::OFF_CTRL, 32'h0000_0002);
      repeat (5) @(posedge pclk);
      chk("busy_after_stop", 32'h0000_0000, 32'(acq_busy));
      ext_trigger <= 1'b1;
      repeat (10) @(posedge pclk);
      chk("busy_retrigger", 32'h0000_0001, 32'(acq_busy));
      ext_trigger <= 1'b0;
      repeat (10) @(posedge pclk);
      chk("busy_after_loss", 32'h0000_0000, 32'(acq_busy));
      // Threshold above current 1 peak, then below it
      wr(pmac_pkg::OFF_CFG, 32'h0000_3C08);
      wr(pmac_pkg::OFF_CTRL, 32'h0000_0001);
      per(3);
      rd(pmac_pkg::OFF_STAT);
      chk("gate_below", 32'h0000_0000, 32'(q[2]));
      chk("kept_below", 32'h0000_0000, 32'(q[11:9]));
      wr(pmac_pkg::OFF_CFG, 32'h0000_2808);
      per(2);
      rd(pmac_pkg::OFF_STAT);
      chk("gate_above", 32'h0000_0001, 32'(q[2]));
   endtask
   ////////////////////////////////////////////////////////////
   task automatic results;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      #400000;
      miscompares++;
      results();
   end
   initial
   begin
      presetn = 1'b0;
      ext_trigger = 1'b0;
      sv = 16'h4000;
      cnt = 7'h00;
      adc_valid = 1'b0;
      mains_tick = 1'b0;
      adc_sample = 96'h0;
      miscompares = 0;
      num_checks = 0;
      repeat (4) @(posedge pclk);
      chk("busy_in_reset", 32'h0000_0000, 32'(acq_busy));
      chk("xfer_in_reset", 32'h0000_0000, 32'(xfer.valid));
      presetn <= 1'b1;
      host.xfr(1'b0, 8'hF0, 32'h0000_0000, q, e);
      chk("unmapped_err", 32'h0000_0001, 32'(e));
      chk("unmapped_data", 32'h0000_0000, q);
      rchk("ctrl_read", pmac_pkg::OFF_CTRL, 32'h0000_0000);
      t_nets();
      t_continuous_mode();
      t_external_trigger_input();
      results();
   end
endmodule
`default_nettype wire
